// ===== gxp_pkg.sv
// Constants, types and register map of the 16-pin serial GPIO expander
package gxp_pkg;

  // Register codes held in the pointer nibble
  localparam logic [3:0] REG_INPUT0 = 4'h0;
  localparam logic [3:0] REG_INPUT1 = 4'h1;
  localparam logic [3:0] REG_POL0 = 4'h2;
  localparam logic [3:0] REG_POL1 = 4'h3;
  localparam logic [3:0] REG_HOLD0 = 4'h4;
  localparam logic [3:0] REG_HOLD1 = 4'h5;
  localparam logic [3:0] REG_PULL0 = 4'h6;
  localparam logic [3:0] REG_PULL1 = 4'h7;
  localparam logic [3:0] REG_DIR0 = 4'h8;
  localparam logic [3:0] REG_DIR1 = 4'h9;
  localparam logic [3:0] REG_OUTPUT_LATCH_BANK0 = 4'ha;
  localparam logic [3:0] REG_OUTPUT_LATCH_BANK1 = 4'hb;
  localparam logic [3:0] REG_MASK0 = 4'hc;
  localparam logic [3:0] REG_MASK1 = 4'hd;
  localparam logic [3:0] REG_STAT0 = 4'he;
  localparam logic [3:0] REG_STAT1 = 4'hf;
  localparam int REG_COUNT = 16;

  // Pin organisation
  localparam int BANK_W = 8;
  localparam int PIN_W = 16;

  // Reset values of the writable registers
  localparam logic [7:0] RST_POL = 8'h00;
  localparam logic [7:0] RST_HOLD = 8'h00;
  localparam logic [7:0] RST_PULL = 8'h00;
  localparam logic [7:0] RST_DIR = 8'hff;
  localparam logic [7:0] RST_OUT = 8'h00;
  localparam logic [7:0] RST_MASK = 8'hff;
  localparam logic [7:0] RST_CMD = 8'h00;

  // Field positions
  localparam int HOLD_EN_BIT = 0;
  localparam int CMD_AI_BIT = 7;
  localparam int BYTE_BITS = 8;
  localparam logic [3:0] ACK_SLOT = 4'h8;

  // Slave address: upper bits fixed, low nibble fixed or strapped
  localparam logic [2:0] ADDR_UPPER = 3'h2;
  localparam logic [3:0] ADDR_FIXED_LOW = 4'h0;

  // Stored command byte
  typedef struct packed {
    logic autoinc;
    logic [2:0] spare;
    logic [3:0] ptr;
  } gxp_cmd_s;

  // Protocol states of the serial slave
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_CMD,
    ST_WDATA,
    ST_RDATA,
    ST_IGNORE
  } gxp_state_e;

endpackage

// ===== gxp_sync.sv
// Two-stage synchroniser for pins arriving from outside the clock domain
`timescale 1ns/1ns
module gxp_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  // First stage, read only by the second stage
  logic [W-1:0] meta_ff;

  // Both stages load the idle value under reset
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      meta_ff <= RST_VAL;
      q <= RST_VAL;
    end
    else
    begin
      meta_ff <= d;
      q <= meta_ff;
    end
  end

endmodule

// ===== gxp_expander.sv
// Serial slave front end, register map and pin control of the GPIO expander
`timescale 1ns/1ns
module gxp_expander
  import gxp_pkg::*;
#(
  parameter bit LARGE_VARIANT = 1'b1
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic rst_n,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  input wire logic addr_strap_bit0,
  input wire logic addr_strap_bit1,
  input wire logic addr_strap_bit2,
  input wire logic addr_strap_bit3,
  input wire logic [15:0] gpio_in,
  output logic [15:0] gpio_out,
  output logic [15:0] gpio_oe_n,
  output logic [1:0] keeper_en,
  output logic [1:0] pull_en,
  output logic [15:0] pull_up_sel,
  output logic int_out,
  output logic int_oe_n
);

  // Synchronised pins
  logic scl_s;
  logic sda_s;
  logic rst_n_s;
  logic [3:0] strap_s;
  logic [15:0] gpio_s;
  // Combined reset: core reset or low level on the reset pin
  logic dev_rst;
  // Protocol state
  gxp_state_e state_ff;
  logic scl_prev_ff;
  logic sda_prev_ff;
  logic [3:0] bit_cnt_ff;
  logic [7:0] shift_ff;
  logic in_ack_ff;
  logic ack_ok_ff;
  logic read_op_ff;
  logic drive_low_ff;
  // Command pointer and register storage
  gxp_cmd_s cmd_ff;
  logic [7:0] reg_ff [REG_COUNT];
  logic [6:0] my_addr_ff;
  // Interrupt state
  logic [15:0] gpio_prev_ff;
  logic [15:0] irq_status_ff;
  // Decoded events
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic [3:0] ptr_next;
  logic load_read;
  logic [3:0] load_ptr;
  logic [15:0] change_set;
  logic [15:0] read_clear;
  logic [7:0] read_byte; // Register value fetched for the next read byte

  // One synchroniser for every pin; clock and data lines idle high
  gxp_sync #(.W(23), .RST_VAL(23'h60_0000)) u_pin_sync (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .d({scl_in, sda_in, rst_n, addr_strap_bit3, addr_strap_bit2, addr_strap_bit1,
        addr_strap_bit0, gpio_in}),
    .q({scl_s, sda_s, rst_n_s, strap_s, gpio_s})
  );

  // Reset pin is active low
  assign dev_rst = sys_rst | ~rst_n_s;
  // Reset value of each register code
  function automatic logic [7:0] reg_reset(input logic [3:0] idx);
    logic [7:0] v;
    v = 8'h00;
    unique case (idx)
      REG_POL0, REG_POL1: v = RST_POL;
      REG_HOLD0, REG_HOLD1: v = RST_HOLD;
      REG_PULL0, REG_PULL1: v = RST_PULL;
      REG_DIR0, REG_DIR1: v = RST_DIR;
      REG_OUTPUT_LATCH_BANK0, REG_OUTPUT_LATCH_BANK1: v = RST_OUT;
      REG_MASK0, REG_MASK1: v = RST_MASK;
      default: v = 8'h00;
    endcase
    return v;
  endfunction
  // Codes that software may change; input and status codes are read only
  function automatic logic reg_writable(input logic [3:0] idx);
    return (idx >= REG_POL0) && (idx <= REG_MASK1);
  endfunction
  // Every nibble value names a defined register
  function automatic logic cmd_valid(input logic [3:0] idx);
    return 32'(idx) < REG_COUNT;
  endfunction
  // Read value of a register code
  function automatic logic [7:0] reg_read(input logic [3:0] idx);
    logic [7:0] v;
    v = reg_ff[idx];
    unique case (idx)
      REG_INPUT0: v = gpio_s[7:0] ^ reg_ff[REG_POL0];
      REG_INPUT1: v = gpio_s[15:8] ^ reg_ff[REG_POL1];
      REG_STAT0: v = irq_status_ff[7:0];
      REG_STAT1: v = irq_status_ff[15:8];
      default: v = reg_ff[idx];
    endcase
    return v;
  endfunction
  // Byte handed to the shifter when a read byte is fetched
  assign read_byte = reg_read(load_ptr);
  // Pointer after a data byte: advance and wrap only with the flag set
  assign ptr_next = cmd_ff.autoinc ? 4'(cmd_ff.ptr + 4'h1) : cmd_ff.ptr;
  // Clock and data edge detection on the synchronised lines
  assign scl_rise = scl_s & ~scl_prev_ff;
  assign scl_fall = ~scl_s & scl_prev_ff;
  assign start_det = scl_s & scl_prev_ff & sda_prev_ff & ~sda_s;
  assign stop_det = scl_s & scl_prev_ff & ~sda_prev_ff & sda_s;
  // A read byte is fetched at the end of the address slot or after a master ack
  always_comb
  begin
    load_read = 1'b0;
    load_ptr = cmd_ff.ptr;
    if (state_ff == ST_ADDR && in_ack_ff && scl_fall && ack_ok_ff && read_op_ff)
    begin
      load_read = 1'b1;
    end
    else if (state_ff == ST_RDATA && scl_rise && bit_cnt_ff == ACK_SLOT && !sda_s)
    begin
      load_read = 1'b1;
      load_ptr = ptr_next;
    end
  end
  // Previous line levels for edge detection
  always_ff @(posedge core_clk)
  begin
    if (dev_rst)
    begin
      scl_prev_ff <= 1'b1;
      sda_prev_ff <= 1'b1;
    end
    else
    begin
      scl_prev_ff <= scl_s;
      sda_prev_ff <= sda_s;
    end
  end
  // Slave address: fixed in the small variant, straps followed while the bus is idle,
  // since the strap synchroniser only settles as the reset pin's synchroniser releases
  always_ff @(posedge core_clk)
  begin
    if (dev_rst || state_ff == ST_IDLE)
    begin
      my_addr_ff <= LARGE_VARIANT ? {ADDR_UPPER, strap_s} : {ADDR_UPPER, ADDR_FIXED_LOW};
    end
  end
  // Byte engine: bit counting, shifting, acknowledge slots and state
  always_ff @(posedge core_clk)
  begin
    if (dev_rst)
    begin
      state_ff <= ST_IDLE;
      bit_cnt_ff <= 4'h0;
      shift_ff <= 8'h00;
      in_ack_ff <= 1'b0;
      ack_ok_ff <= 1'b0;
      read_op_ff <= 1'b0;
      drive_low_ff <= 1'b0;
    end
    else if (start_det)
    begin
      // A start or repeated start always begins a new address byte
      state_ff <= ST_ADDR;
      bit_cnt_ff <= 4'h0;
      in_ack_ff <= 1'b0;
      drive_low_ff <= 1'b0;
    end
    else if (stop_det)
    begin
      // Stop releases the line and ends the transfer
      state_ff <= ST_IDLE;
      in_ack_ff <= 1'b0;
      drive_low_ff <= 1'b0;
    end
    else if (state_ff == ST_RDATA)
    begin
      if (scl_rise && bit_cnt_ff < ACK_SLOT)
      begin
        // Master has sampled the bit, move to the next
        shift_ff <= {shift_ff[6:0], 1'b0};
        bit_cnt_ff <= 4'(bit_cnt_ff + 4'h1);
      end
      else if (scl_rise)
      begin
        // Master ack continues the read, a nack ends it
        if (load_read)
        begin
          shift_ff <= reg_read(load_ptr);
          bit_cnt_ff <= 4'h0;
        end
        else
        begin
          state_ff <= ST_IGNORE;
        end
      end
      else if (scl_fall)
      begin
        // Present the current bit, release for the master's ack slot
        drive_low_ff <= (bit_cnt_ff < ACK_SLOT) && !shift_ff[7];
      end
    end
    else if (state_ff == ST_ADDR || state_ff == ST_CMD || state_ff == ST_WDATA)
    begin
      if (scl_rise && !in_ack_ff && bit_cnt_ff < ACK_SLOT)
      begin
        // Receive one bit, most significant first
        shift_ff <= {shift_ff[6:0], sda_s};
        bit_cnt_ff <= 4'(bit_cnt_ff + 4'h1);
      end
      else if (scl_fall && !in_ack_ff && bit_cnt_ff == ACK_SLOT)
      begin
        // Decide the acknowledge for the byte just received
        in_ack_ff <= 1'b1;
        if (state_ff == ST_ADDR)
        begin
          ack_ok_ff <= shift_ff[7:1] == my_addr_ff;
          drive_low_ff <= shift_ff[7:1] == my_addr_ff;
          read_op_ff <= shift_ff[0];
        end
        else if (state_ff == ST_CMD)
        begin
          ack_ok_ff <= cmd_valid(shift_ff[3:0]);
          drive_low_ff <= cmd_valid(shift_ff[3:0]);
        end
        else
        begin
          ack_ok_ff <= 1'b1;
          drive_low_ff <= 1'b1;
        end
      end
      else if (scl_fall && in_ack_ff)
      begin
        // End of the ack slot: choose the next phase
        in_ack_ff <= 1'b0;
        bit_cnt_ff <= 4'h0;
        drive_low_ff <= 1'b0;
        if (!ack_ok_ff)
        begin
          state_ff <= ST_IGNORE;
        end
        else if (state_ff == ST_ADDR && read_op_ff)
        begin
          state_ff <= ST_RDATA;
          shift_ff <= read_byte;
          drive_low_ff <= !read_byte[7];
        end
        else if (state_ff == ST_ADDR)
        begin
          state_ff <= ST_CMD;
        end
        else
        begin
          state_ff <= ST_WDATA;
        end
      end
    end
  end
  // Command pointer: stored from the command byte, advanced per data byte
  always_ff @(posedge core_clk)
  begin
    if (dev_rst)
    begin
      cmd_ff <= gxp_cmd_s'(RST_CMD);
    end
    else if (scl_fall && !in_ack_ff && bit_cnt_ff == ACK_SLOT && !start_det && !stop_det)
    begin
      if (state_ff == ST_CMD && cmd_valid(shift_ff[3:0]))
      begin
        cmd_ff <= gxp_cmd_s'(shift_ff);
      end
      else if (state_ff == ST_WDATA)
      begin
        cmd_ff.ptr <= ptr_next;
      end
    end
    else if (load_read && state_ff == ST_RDATA && !start_det && !stop_det)
    begin
      cmd_ff.ptr <= ptr_next;
    end
  end
  // Register file: a data byte updates only the pointed register
  always_ff @(posedge core_clk)
  begin
    if (dev_rst)
    begin
      for (int i = 0; i < REG_COUNT; i++)
      begin
        reg_ff[i] <= reg_reset(4'(i));
      end
    end
    else if (state_ff == ST_WDATA && scl_fall && !in_ack_ff && bit_cnt_ff == ACK_SLOT
             && !start_det && !stop_det && reg_writable(cmd_ff.ptr))
    begin
      reg_ff[cmd_ff.ptr] <= shift_ff;
    end
  end
  // Change detection on unmasked input pins
  always_comb
  begin
    for (int b = 0; b < PIN_W; b++)
    begin
      change_set[b] = (gpio_s[b] != gpio_prev_ff[b])
        && !reg_ff[b < BANK_W ? REG_MASK0 : REG_MASK1][b % BANK_W]
        && reg_ff[b < BANK_W ? REG_DIR0 : REG_DIR1][b % BANK_W];
    end
    read_clear = 16'h0000;
    if (load_read && !start_det && !stop_det && load_ptr == REG_INPUT0)
    begin
      read_clear[7:0] = 8'hff;
    end
    if (load_read && !start_det && !stop_det && load_ptr == REG_INPUT1)
    begin
      read_clear[15:8] = 8'hff;
    end
  end
  // Sticky status and interrupt pin: a new change wins over a clear in the same cycle
  always_ff @(posedge core_clk)
  begin
    if (dev_rst)
    begin
      gpio_prev_ff <= 16'h0000;
      irq_status_ff <= 16'h0000;
      int_oe_n <= 1'b1;
    end
    else
    begin
      gpio_prev_ff <= gpio_s;
      irq_status_ff <= (irq_status_ff & ~read_clear) | change_set;
      int_oe_n <= ~|irq_status_ff;
    end
  end
  // Open-drain outputs: enable low pulls the line low
  assign int_out = 1'b0;
  assign sda_out = 1'b0;
  assign sda_oe_n = ~drive_low_ff;
  // Pin drivers, keeper and pull controls per bank
  always_ff @(posedge core_clk)
  begin
    if (dev_rst)
    begin
      gpio_out <= {RST_OUT, RST_OUT};
      gpio_oe_n <= {RST_DIR, RST_DIR};
      keeper_en <= {RST_HOLD[HOLD_EN_BIT], RST_HOLD[HOLD_EN_BIT]};
      pull_en <= ~{RST_HOLD[HOLD_EN_BIT], RST_HOLD[HOLD_EN_BIT]};
      pull_up_sel <= {RST_PULL, RST_PULL};
    end
    else
    begin
      gpio_out <= {reg_ff[REG_OUTPUT_LATCH_BANK1], reg_ff[REG_OUTPUT_LATCH_BANK0]};
      gpio_oe_n <= {reg_ff[REG_DIR1], reg_ff[REG_DIR0]};
      keeper_en <= {reg_ff[REG_HOLD1][HOLD_EN_BIT], reg_ff[REG_HOLD0][HOLD_EN_BIT]};
      pull_en <= ~{reg_ff[REG_HOLD1][HOLD_EN_BIT], reg_ff[REG_HOLD0][HOLD_EN_BIT]};
      pull_up_sel <= {reg_ff[REG_PULL1], reg_ff[REG_PULL0]};
    end
  end

endmodule

// ===== gxp_master.sv
// Bus master model on the serial clock and data lines
`timescale 1ns/1ns
module gxp_master (
  input wire logic core_clk,
  input wire logic sda,
  output logic scl,
  output logic sda_oe_n
);
  // Both lines idle released and high
  initial
  begin
    scl = 1'b1;
    sda_oe_n = 1'b1;
  end

  // One bit: data set while the clock is low, sampled at the end of the high phase
  task automatic bit_x(input logic b, output logic r);
    @(posedge core_clk) sda_oe_n <= b;
    repeat (3) @(posedge core_clk);
    scl <= 1'b1;
    repeat (4) @(posedge core_clk);
    r = sda;
    scl <= 1'b0;
  endtask

  // Start or repeated start: data falls while the clock is high
  task automatic start;
    @(posedge core_clk) sda_oe_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    scl <= 1'b1;
    repeat (4) @(posedge core_clk);
    sda_oe_n <= 1'b0;
    repeat (4) @(posedge core_clk);
    scl <= 1'b0;
  endtask

  // Stop: data rises while the clock is high, bus then left idle
  task automatic stop;
    @(posedge core_clk) sda_oe_n <= 1'b0;
    repeat (3) @(posedge core_clk);
    scl <= 1'b1;
    repeat (4) @(posedge core_clk);
    sda_oe_n <= 1'b1;
    repeat (4) @(posedge core_clk);
  endtask

  // Byte MSB first, then the answer slot (n high releases it)
  task automatic xbyte(input logic [7:0] d, input logic n, output logic [7:0] q, output logic a);
    for (int i = 7; i >= 0; i--)
      bit_x(d[i], q[i]);
    bit_x(n, a);
  endtask
endmodule

// ===== gxp_expander_sva.sv
// Assertions on the pins of the GPIO expander
`timescale 1ns/1ns
module gxp_expander_chk (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic rst_n,
  input wire logic scl_in,
  input wire logic [15:0] gpio_in,
  input wire logic sda_out,
  input wire logic sda_oe_n,
  input wire logic [15:0] gpio_out,
  input wire logic [15:0] gpio_oe_n,
  input wire logic [1:0] keeper_en,
  input wire logic [1:0] pull_en,
  input wire logic [15:0] pull_up_sel,
  input wire logic int_out,
  input wire logic int_oe_n
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);
  logic [15:0] pins_ff; // Pin levels one cycle back
  logic [4:0] quiet_cnt_ff; // Cycles since the pins last moved, saturating

  // Quiet counter restarts on any pin change
  always_ff @(posedge core_clk)
  begin
    pins_ff <= gpio_in;
    if (sys_rst || gpio_in != pins_ff)
      quiet_cnt_ff <= 5'h00;
    else if (quiet_cnt_ff != 5'h1f)
      quiet_cnt_ff <= quiet_cnt_ff + 5'h01;
  end

  AST_SDA_VALUE: assert property (sda_out == 1'b0)
    else $error("data value not zero");
  AST_INT_VALUE: assert property (int_out == 1'b0)
    else $error("interrupt value not zero");
  AST_PULL_XOR: assert property (pull_en == ~keeper_en)
    else $error("keeper and pull both on or both off");
  AST_DATA_MOVES_LOW: assert property ($changed(sda_oe_n) |-> !scl_in)
    else $error("data changed while clock high");
  AST_DATA_HELD: assert property ($fell(sda_oe_n) |=> (!sda_oe_n)[*5])
    else $error("data low too short");
  AST_INT_QUIET: assert property (quiet_cnt_ff > 5'h0f && int_oe_n |=> int_oe_n)
    else $error("interrupt without pin change");
  AST_PIN_RESET: assert property ((!rst_n)[*6] |-> gpio_oe_n == 16'hffff && int_oe_n)
    else $error("reset pin did not restore pins");
  AST_RST_OUT: assert property ($fell(sys_rst) |-> gpio_out == 16'h0000
    && keeper_en == 2'b00 && pull_up_sel == 16'h0000 && sda_oe_n)
    else $error("wrong state after reset");
endmodule

bind gxp_expander gxp_expander_chk i_gxp_expander_chk (
  .core_clk(core_clk), .sys_rst(sys_rst), .rst_n(rst_n), .scl_in(scl_in),
  .gpio_in(gpio_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .gpio_out(gpio_out),
  .gpio_oe_n(gpio_oe_n), .keeper_en(keeper_en), .pull_en(pull_en),
  .pull_up_sel(pull_up_sel), .int_out(int_out), .int_oe_n(int_oe_n)
);

// ===== tb_gxp_expander.sv
// Self-checking bench for the GPIO expander register map
`timescale 1ns/1ns
module tb_gxp_expander
  import gxp_pkg::*;
;
  localparam logic [6:0] DEV = {ADDR_UPPER, 4'ha}; // Strapped slave address
  localparam logic [7:0] DFLT [12] = '{RST_POL, RST_POL, RST_HOLD, RST_HOLD,
    RST_PULL, RST_PULL, RST_DIR, RST_DIR, RST_OUT, RST_OUT, RST_MASK, RST_MASK};
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic rst_n = 1'b1;
  logic [15:0] gpio_in = 16'h3c5a;
  logic scl, m_oe_n, sda, sda_out, sda_oe_n, int_out, int_oe_n, ba;
  logic [15:0] gpio_out, gpio_oe_n, pull_up_sel;
  logic [1:0] keeper_en, pull_en;
  logic [7:0] bq;
  logic [7:0] wq [16];
  logic [7:0] rq [16];
  int errors = 0;
  int compares = 0;

  // Wired data line with pull-up
  assign sda = m_oe_n & sda_oe_n;

  gxp_expander #(.LARGE_VARIANT(1'b1)) i_gxp_expander (
    .core_clk(core_clk), .sys_rst(sys_rst), .rst_n(rst_n), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .addr_strap_bit0(1'b0), .addr_strap_bit1(1'b1),
    .addr_strap_bit2(1'b0), .addr_strap_bit3(1'b1), .gpio_in(gpio_in), .gpio_out(gpio_out),
    .gpio_oe_n(gpio_oe_n), .keeper_en(keeper_en), .pull_en(pull_en),
    .pull_up_sel(pull_up_sel), .int_out(int_out), .int_oe_n(int_oe_n));

  gxp_master i_gxp_master (.core_clk(core_clk), .sda(sda), .scl(scl), .sda_oe_n(m_oe_n));

  // Clock, 20 ns period
  initial
  begin
    forever #10 core_clk = ~core_clk;
  end

  // Compare one result
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Start, address with write, command byte
  task automatic head(input logic [7:0] cmd);
    i_gxp_master.start();
    i_gxp_master.xbyte({DEV, 1'b0}, 1'b1, bq, ba);
    chk({15'h0000, ba}, 16'h0000);
    i_gxp_master.xbyte(cmd, 1'b1, bq, ba);
    chk({15'h0000, ba}, 16'h0000);
  endtask

  // Write n bytes from wq
  task automatic wr(input logic [7:0] cmd, input int n);
    head(cmd);
    for (int i = 0; i < n; i++)
    begin
      i_gxp_master.xbyte(wq[i], 1'b1, bq, ba);
      chk({15'h0000, ba}, 16'h0000);
    end
    i_gxp_master.stop();
  endtask

  // Read n bytes into rq at the current pointer, last one refused
  task automatic rd_cur(input int n);
    i_gxp_master.start();
    i_gxp_master.xbyte({DEV, 1'b1}, 1'b1, bq, ba);
    chk({15'h0000, ba}, 16'h0000);
    for (int i = 0; i < n; i++)
      i_gxp_master.xbyte(8'hff, i == n - 1, rq[i], ba);
    i_gxp_master.stop();
  endtask

  // Read with command write and repeated start
  task automatic rd(input logic [7:0] cmd, input int n);
    head(cmd);
    rd_cur(n);
  endtask

  task automatic t_defaults;
    chk(gpio_oe_n, 16'hffff);
    chk({12'h000, keeper_en, pull_en}, 16'h0003);
    rd_cur(1);
    chk({8'h00, rq[0]}, {8'h00, gpio_in[7:0]});
    rd(8'h82, 12);
    for (int i = 0; i < 12; i++)
      chk({8'h00, rq[i]}, {8'h00, DFLT[i]});
    $display("test defaults done");
  endtask

  task automatic t_irq;
    wq[0] = 8'hfe;
    wr(8'h0c, 1);
    @(posedge core_clk) gpio_in <= gpio_in ^ 16'h0002;
    repeat (10) @(posedge core_clk);
    chk({15'h0000, int_oe_n}, 16'h0001);
    @(posedge core_clk) gpio_in <= gpio_in ^ 16'h0001;
    repeat (10) @(posedge core_clk);
    chk({15'h0000, int_oe_n}, 16'h0000);
    rd(8'h0e, 1);
    chk({8'h00, rq[0]}, 16'h0001);
    rd(8'h01, 1);
    chk({15'h0000, int_oe_n}, 16'h0000);
    rd(8'h00, 1);
    chk({15'h0000, int_oe_n}, 16'h0001);
    $display("test irq done");
  endtask

  task automatic t_codes;
    for (int i = 0; i < REG_COUNT; i++)
      wr({4'h7, i[3:0]}, 0);
    i_gxp_master.start();
    i_gxp_master.xbyte({ADDR_UPPER, 4'hb, 1'b0}, 1'b1, bq, ba);
    chk({15'h0000, ba}, 16'h0001);
    i_gxp_master.stop();
    $display("test codes done");
  endtask

  task automatic t_write;
    wq[0] = 8'h3c;
    wq[1] = 8'hc3;
    wr(8'h8a, 2);
    chk(gpio_out, 16'hc33c);
    wq[0] = 8'h00;
    wq[1] = 8'h0f;
    wr(8'h88, 2);
    chk(gpio_oe_n, 16'h0f00);
    rd(8'h88, 4);
    chk({rq[1], rq[0]}, 16'h0f00);
    chk({rq[3], rq[2]}, 16'hc33c);
    $display("test write done");
  endtask

  task automatic t_wrap;
    wq[0] = 8'h11;
    wq[1] = 8'h22;
    wq[2] = 8'h33;
    wq[3] = 8'hff;
    wr(8'h8f, 4);
    chk(gpio_out, 16'hc33c);
    rd(8'h02, 2);
    chk({rq[1], rq[0]}, 16'hffff);
    rd(8'h00, 1);
    chk({8'h00, rq[0]}, {8'h00, ~gpio_in[7:0]});
    $display("test wrap done");
  endtask

  task automatic t_hold;
    wq[0] = 8'h01;
    wq[1] = 8'h00;
    wq[2] = 8'hf0;
    wq[3] = 8'h0f;
    wr(8'h84, 4);
    chk({12'h000, keeper_en, pull_en}, 16'h0006);
    chk(pull_up_sel, 16'h0ff0);
    $display("test hold done");
  endtask

  task automatic t_rstpin;
    @(posedge core_clk) rst_n <= 1'b0;
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (8) @(posedge core_clk);
    chk(gpio_out, 16'h0000);
    chk(gpio_oe_n, 16'hffff);
    rd(8'h02, 1);
    chk({8'h00, rq[0]}, 16'h0000);
    $display("test reset pin done");
  endtask

  // Counts and verdict, then end of run
  task automatic print_verdict;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Watchdog against a hung bus
  initial
  begin
    repeat (60000) @(posedge core_clk);
    errors++;
    print_verdict();
  end

  // Main sequence
  initial
  begin
    repeat (4) @(posedge core_clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge core_clk);
    t_defaults();
    t_irq();
    t_codes();
    t_write();
    t_wrap();
    t_hold();
    t_rstpin();
    print_verdict();
  end
endmodule
